// ==== src/pll_counter_switchover_reconfig.sv ====
`timescale 1ns/10ps
// Functional notes
// - one pre-divider and one feedback multiplier, each 1 to 512.
// - two regional, four global, four external post counters, each 1 to 512.
// - loop drives VCO to reference times multiplier over pre-divider.
// - every output comes from a post counter dividing the VCO; pair outputs and the single output share counters.
// - lost primary edges move the reference to the secondary input.
// - external switch request forces switchover; user asserts it for unequal references.
// - gated lock going low switches to the secondary reference.
// - reference mux change is glitch free, no runt pulse reaches detector.
// - VCO keeps running during switchover; output drifts until relock.
// - lock regained within 100 microseconds after switchover.
// - running logic rewrites counters and delays without full reconfiguration.
// - each output has a variable delay element held in reconfigurable state.
// - bits shift in serially on a dedicated shift clock into a chain.
// - after the last bit the chain loads into active settings at once.
// - asynchronous clear resets the chain regardless of the shift clock.
// - whole reconfiguration takes under 20 microseconds at 25 MHz shift clock.
// - chain never touches charge pump, loop filter or phase taps.
// - only instances 5 and 6 offer external feedback.
// - instances 11 and 12 drive their single output from first global counter.
// - instances 5 and 6 drive eight single or four pair outputs from external counters.
// - delay elements step by 250 ps; they change during operation along with the counters.
module pll_counter_switchover_reconfig #(
  parameter int INSTANCE_ID = 5,
  parameter int RELOCK_LIMIT = pll_ctrl_pkg::RELOCK_CYCLES,
  parameter logic [31:0] NCO_INIT = pll_ctrl_pkg::NCO_RESET
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reference_input_zero_i,
  input wire logic reference_input_one_i,
  input wire logic ext_switch_request_i,
  input wire logic fb_in_i,
  input wire logic scan_clk_i,
  input wire logic scan_data_i,
  input wire logic scan_clear_i,
  output logic vco_tick_o,
  output logic active_ref_o,
  output logic locked_o,
  output logic [1:0] regional_clk_o,
  output logic [3:0] global_clk_o,
  output logic [3:0] ext_out_a_o,
  output logic [3:0] ext_out_b_o,
  output logic single_ext_out_o,
  output logic [pll_ctrl_pkg::NUM_POST*pll_ctrl_pkg::DELAY_W-1:0] delay_step_o
);
  import pll_ctrl_pkg::*;

  localparam int NPIN = 6;
  localparam bit EXT_FB_OK = (INSTANCE_ID == 5) || (INSTANCE_ID == 6);
  localparam bit SINGLE_OUT = (INSTANCE_ID == 11) || (INSTANCE_ID == 12);

  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_prev_q;
  logic [NPIN-1:0] rise;
  logic [7:0] ctrl_q;
  logic relock_to_q, reconf_done_q, sw_event_q;
  logic [DIV_W*NUM_DIV-1:0] div_cfg_q;
  logic [DELAY_W*NUM_POST-1:0] delay_cfg_q;
  logic [CHAIN_LEN-1:0] chain_q;
  logic [CHAIN_CNT_W-1:0] chain_cnt_q;
  logic load_q, sel_q, pend_q;
  logic [6:0] loss_cnt_q;
  logic primary_lost;
  logic lock_prev_q;
  logic [31:0] acc_q, incr_q;
  logic [32:0] acc_sum;
  logic signed [7:0] err_q;
  logic [4:0] lock_cnt_q;
  logic [16:0] relock_cnt_q;
  logic [NUM_DIV-1:0] div_tick, div_pulse, div_clk;
  logic wb_req, wb_wr, wb_rd_en, switch_now;
  logic [31:0] status_word;
  logic [3:0] hit;

  // decodes a register address to a one-hot select
  function automatic logic [3:0] reg_hit(input logic [7:0] adr);
    reg_hit = {adr == NCO_OFFSET, adr == DIVNM_OFFSET, adr == STATUS_OFFSET, adr == CTRL_OFFSET};
  endfunction : reg_hit
  assign hit = reg_hit(wb_adr_i); // one decode shared by every register access

  assign pin_in = {scan_data_i, scan_clk_i, fb_in_i, ext_switch_request_i,
                   reference_input_one_i, reference_input_zero_i};

  // three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
      lvl_prev_q <= '0;
    end
    else if (ce_i)
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
      lvl_prev_q <= lvl_q;
    end
  end
  assign rise = lvl_q & ~lvl_prev_q;

  // clock sense: count cycles since the last primary edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ce_i && (rise[0] || switch_now))) // sensing restarts after each switch
      loss_cnt_q <= '0;
    else if (ce_i && loss_cnt_q != 7'(LOSS_CYCLES))
      loss_cnt_q <= loss_cnt_q + 7'h01;
  end
  assign primary_lost = loss_cnt_q == 7'(LOSS_CYCLES);

  // switch request register; the mux moves only while both references sit low
  assign switch_now = pend_q && !lvl_q[0] && !lvl_q[1];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_q <= 1'b0;
      sel_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end
    else if (ce_i)
    begin
      lock_prev_q <= locked_o && !switch_now && !load_q; // lock drops from a switch or reload are no loss
      if (switch_now)
      begin
        pend_q <= 1'b0;
        sel_q <= ~sel_q;
      end
      else if (!sel_q && ctrl_q[CTRL_AUTO_SENSE_BIT] && primary_lost)
        pend_q <= 1'b1;
      else if (!sel_q && ctrl_q[CTRL_GATED_LOCK_BIT] && lock_prev_q && !locked_o)
        pend_q <= 1'b1;
      else if ((ctrl_q[CTRL_EXT_SWITCH_BIT] && rise[2]) || (wb_wr && hit[0] && wb_sel_i[0]
               && wb_dat_i[CTRL_MANUAL_SWITCH_BIT]))
        pend_q <= 1'b1;
    end
  end
  assign active_ref_o = sel_q;

  // digital VCO: phase accumulator that never stops, also across a switch
  assign acc_sum = {1'b0, acc_q} + {1'b0, incr_q};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_q <= '0;
      vco_tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      acc_q <= acc_sum[31:0];
      vco_tick_o <= acc_sum[32];
    end
  end

  // divider inputs: reference into pre-divider, VCO or external feedback into multiplier
  always_comb
  begin
    div_tick = {NUM_DIV{vco_tick_o}};
    div_tick[0] = sel_q ? rise[1] : rise[0];
    div_tick[1] = (EXT_FB_OK && ctrl_q[CTRL_EXT_FB_BIT]) ? rise[3] : vco_tick_o;
  end

  // one divider per counter, all programmable 1 to 512
  generate
    for (genvar g = 0; g < NUM_DIV; g++)
    begin : g_div
      pll_divider #(
        .W(DIV_W)
      ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .restart_i(load_q),
        .tick_i(div_tick[g]),
        .div_i(div_cfg_q[g*DIV_W +: DIV_W]),
        .pulse_o(div_pulse[g]),
        .clk_o(div_clk[g])
      );
    end
  endgenerate

  // frequency loop: ref/n against vco/m steers the accumulator increment
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      err_q <= '0;
      incr_q <= NCO_INIT;
      lock_cnt_q <= '0;
      locked_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (load_q || switch_now)
      begin
        err_q <= '0;
        lock_cnt_q <= '0;
        locked_o <= 1'b0;
      end
      else
      begin
        if (div_pulse[0] && !div_pulse[1] && err_q < ERR_LIMIT)
          err_q <= err_q + 8'sh01;
        else if (div_pulse[1] && !div_pulse[0] && err_q > -ERR_LIMIT)
          err_q <= err_q - 8'sh01;
        if (div_pulse[0] && !ctrl_q[CTRL_FLL_HOLD_BIT] && !pend_q)
        begin
          if (err_q > 8'sh01)
            incr_q <= incr_q + NCO_STEP;
          else if (err_q < -8'sh01)
            incr_q <= incr_q - NCO_STEP;
          if (err_q >= -8'sh01 && err_q <= 8'sh01)
          begin
            if (lock_cnt_q != 5'(LOCK_PULSES))
              lock_cnt_q <= lock_cnt_q + 5'h01;
            else
              locked_o <= 1'b1;
          end
          else
          begin
            lock_cnt_q <= '0;
            locked_o <= 1'b0;
          end
        end
      end
    end
  end

  // relock watchdog started by each switch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      relock_cnt_q <= '0;
    else if (ce_i)
    begin
      if (switch_now)
        relock_cnt_q <= 17'(RELOCK_LIMIT);
      else if (locked_o)
        relock_cnt_q <= '0;
      else if (relock_cnt_q != '0)
        relock_cnt_q <= relock_cnt_q - 17'h00001;
    end
  end

  // serial chain on the shift clock edge; cleared at once by the clear pin
  always_ff @(posedge clk_i or posedge scan_clear_i)
  begin
    if (scan_clear_i)
    begin
      chain_q <= '0;
      chain_cnt_q <= '0;
      load_q <= 1'b0;
    end
    else if (ce_i)
    begin
      load_q <= 1'b0;
      if (rise[4])
      begin
        chain_q <= {chain_q[CHAIN_LEN-2:0], lvl_q[5]};
        if (chain_cnt_q == CHAIN_CNT_W'(CHAIN_LEN - 1))
        begin
          chain_cnt_q <= '0;
          load_q <= 1'b1;
        end
        else
          chain_cnt_q <= chain_cnt_q + 8'h01;
      end
    end
  end

  // one-shot transfer of the chain into live counter and delay settings
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cfg_q <= {NUM_DIV{DIV_RESET}};
      delay_cfg_q <= {NUM_POST{DELAY_RESET}};
    end
    else if (ce_i && load_q)
    begin
      div_cfg_q <= chain_q[CHAIN_DELAY_BASE-1:0];
      delay_cfg_q <= chain_q[CHAIN_LEN-1:CHAIN_DELAY_BASE];
    end
  end
  assign delay_step_o = delay_cfg_q;

  // output routing per instance flavour
  always_comb
  begin
    regional_clk_o = div_clk[POST_REGIONAL_BASE +: 2];
    global_clk_o = div_clk[POST_GLOBAL_BASE +: 4];
    ext_out_a_o = EXT_FB_OK ? div_clk[POST_EXTERNAL_BASE +: 4] : 4'h0;
    ext_out_b_o = EXT_FB_OK ? (div_clk[POST_EXTERNAL_BASE +: 4] ^ {4{ctrl_q[CTRL_INVERT_B_BIT]}}) : 4'h0;
    single_ext_out_o = SINGLE_OUT ? div_clk[POST_GLOBAL_BASE] : 1'b0;
  end

  // wishbone slave: one wait state, ack drops the cycle after it rose
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = ce_i && wb_req && wb_we_i;
  assign wb_rd_en = ce_i && wb_req && !wb_we_i;
  assign status_word = {16'h0000, chain_cnt_q, 1'b0, sw_event_q, reconf_done_q, relock_to_q,
                        pend_q, primary_lost, locked_o, sel_q};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      if (wb_rd_en)
      begin
        unique case (1'b1)
          hit[0]: wb_dat_o <= {24'h000000, ctrl_q};
          hit[1]: wb_dat_o <= status_word;
          hit[2]: wb_dat_o <= {7'h00, div_cfg_q[DIV_W +: DIV_W], 7'h00, div_cfg_q[0 +: DIV_W]};
          hit[3]: wb_dat_o <= incr_q;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control register; the manual switch bit reads back as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= CTRL_RESET;
    else if (wb_wr && hit[0] && wb_sel_i[0])
    begin
      ctrl_q <= wb_dat_i[7:0];
      ctrl_q[CTRL_MANUAL_SWITCH_BIT] <= 1'b0;
    end
  end

  // sticky status flags, write one to clear, a new event wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      relock_to_q <= 1'b0;
      reconf_done_q <= 1'b0;
      sw_event_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (relock_cnt_q == 17'h00001 && !locked_o)
        relock_to_q <= 1'b1;
      else if (wb_wr && hit[1] && wb_sel_i[0] && wb_dat_i[STAT_RELOCK_TIMEOUT_BIT])
        relock_to_q <= 1'b0;
      if (load_q)
        reconf_done_q <= 1'b1;
      else if (wb_wr && hit[1] && wb_sel_i[0] && wb_dat_i[STAT_RECONFIG_DONE_BIT])
        reconf_done_q <= 1'b0;
      if (switch_now)
        sw_event_q <= 1'b1;
      else if (wb_wr && hit[1] && wb_sel_i[0] && wb_dat_i[STAT_SWITCH_EVENT_BIT])
        sw_event_q <= 1'b0;
    end
  end
endmodule : pll_counter_switchover_reconfig

// ==== src/pll_ctrl_pkg.sv ====
package pll_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] DIVNM_OFFSET = 8'h08;
  localparam logic [7:0] NCO_OFFSET = 8'h0C;
  // control bits
  localparam int CTRL_AUTO_SENSE_BIT = 0;
  localparam int CTRL_EXT_SWITCH_BIT = 1;
  localparam int CTRL_GATED_LOCK_BIT = 2;
  localparam int CTRL_EXT_FB_BIT = 3;
  localparam int CTRL_INVERT_B_BIT = 4;
  localparam int CTRL_MANUAL_SWITCH_BIT = 5;
  localparam int CTRL_FLL_HOLD_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h07;
  // status bits
  localparam int STAT_ACTIVE_REF_BIT = 0;
  localparam int STAT_LOCKED_BIT = 1;
  localparam int STAT_PRIMARY_LOST_BIT = 2;
  localparam int STAT_PENDING_BIT = 3;
  localparam int STAT_RELOCK_TIMEOUT_BIT = 4;
  localparam int STAT_RECONFIG_DONE_BIT = 5;
  localparam int STAT_SWITCH_EVENT_BIT = 6;
  localparam int STAT_CHAIN_COUNT_LSB = 8;
  localparam int DIVNM_M_LSB = 16;
  // counter set: index 0 pre-divider, 1 feedback multiplier, then ten post-scale counters
  localparam int DIV_W = 9;
  localparam int NUM_POST = 10;
  localparam int NUM_DIV = NUM_POST + 2;
  localparam int POST_REGIONAL_BASE = 2;
  localparam int POST_GLOBAL_BASE = 4;
  localparam int POST_EXTERNAL_BASE = 8;
  localparam int DELAY_W = 5;
  localparam int CHAIN_DELAY_BASE = NUM_DIV * DIV_W;
  localparam int CHAIN_LEN = CHAIN_DELAY_BASE + NUM_POST * DELAY_W;
  localparam int CHAIN_CNT_W = 8;
  localparam logic [DIV_W-1:0] DIV_RESET = 9'h001;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 5'h00;
  localparam int DELAY_STEP_PS = 250;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int RELOCK_TIME_US = 100;
  localparam int RELOCK_CYCLES = RELOCK_TIME_US * CLK_MHZ;
  localparam int RECONFIG_TIME_US = 20;
  localparam int SHIFT_CLK_MHZ = 25;
  localparam int RECONFIG_MAX_BITS = RECONFIG_TIME_US * SHIFT_CLK_MHZ;
  localparam int LOSS_CYCLES = 64;
  localparam int LOCK_PULSES = 16;
  localparam logic [31:0] NCO_RESET = 32'h1000_0000;
  localparam logic [31:0] NCO_STEP = 32'h0000_1000;
  localparam logic signed [7:0] ERR_LIMIT = 8'sh40;
endpackage : pll_ctrl_pkg

// ==== src/pll_divider.sv ====
`timescale 1ns/10ps
// programmable divider: divides tick_i by div_i, 0 meaning 512
module pll_divider #(
  parameter int W = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic tick_i,
  input wire logic [W-1:0] div_i,
  output logic pulse_o,
  output logic clk_o
);
  logic [W:0] full;
  logic [W:0] cnt_q;
  logic [W:0] cnt_d;

  // terminal count, zero code stands for the largest ratio
  always_comb
  begin
    full = (div_i == '0) ? {1'b1, {W{1'b0}}} : {1'b0, div_i};
    cnt_d = (cnt_q <= {{W{1'b0}}, 1'b1}) ? full : cnt_q - {{W{1'b0}}, 1'b1};
  end

  // count down on each input tick and reload at the end of a period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart_i)
    begin
      cnt_q <= {{W{1'b0}}, 1'b1};
      pulse_o <= 1'b0;
      clk_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pulse_o <= tick_i && (cnt_q <= {{W{1'b0}}, 1'b1});
      if (tick_i)
      begin
        cnt_q <= cnt_d;
        clk_o <= cnt_d > {1'b0, full[W:1]}; // high in the first half period
      end
    end
  end
endmodule : pll_divider

// ==== verif/pll_counter_switchover_reconfig_bench.sv ====
`timescale 1ns/10ps
module pll_counter_switchover_reconfig_bench;
  import pll_ctrl_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, ref0, ref1, en0, ext_req, scan_clk, scan_data, scan_clear, go, vco, act, lck;
  logic [3:0] ph = 4'h0;
  logic [7:0] adr, half;
  logic [31:0] wdat, rdat, dat_o;
  logic [1:0] reg_clk;
  logic [3:0] glb, ea, eb;
  logic [49:0] dly, old_dly;
  logic [CHAIN_LEN-1:0] chain;
  logic [9:0] outs;
  int bad_count, total_checks, seed, n, div_d[NUM_DIV];
  assign outs = {ea, glb, reg_clk};
  pll_counter_switchover_reconfig #(.INSTANCE_ID(5), .RELOCK_LIMIT(200)) pll_counter_switchover_reconfig_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .reference_input_zero_i(ref0),
    .reference_input_one_i(ref1), .ext_switch_request_i(ext_req), .fb_in_i(ea[0]), .scan_clk_i(scan_clk),
    .scan_data_i(scan_data), .scan_clear_i(scan_clear), .vco_tick_o(vco), .active_ref_o(act), .locked_o(lck),
    .regional_clk_o(reg_clk), .global_clk_o(glb), .ext_out_a_o(ea), .ext_out_b_o(eb), .single_ext_out_o(),
    .delay_step_o(dly));
  scan_feeder scan_feeder_i (.clk_i(clk_i), .go_i(go), .half_i(half), .bits_i(chain), .scan_clk_o(scan_clk),
    .scan_data_o(scan_data));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // two in-phase references of sixteen cycles, matching the idle vco rate; the primary can be stopped
  always @(posedge clk_i)
  begin
    ph <= ph + 4'h1;
    ref0 <= en0 & ph[3];
    ref1 <= ph[3];
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // one classic bus cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (k >= 50) bad_count++;
  endtask : wb
  function automatic logic [63:0] pick(input int which);
    case (which)
      0: pick = 64'(act);
      1: pick = 64'(lck);
      default: pick = 64'(dly);
    endcase
  endfunction : pick
  task automatic wait_for(input int which, input logic [63:0] v, input int lim);
    n = 0;
    while (n < lim && pick(which) !== v)
    begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    check(pick(which), v);
  endtask : wait_for
  // random chain: pre-divider and multiplier 1..512 or 512, post counters 2..5
  task automatic build(input logic big);
    for (int i = 0; i < NUM_DIV; i++)
    begin
      div_d[i] = (i < 2) ? (big ? 512 : 1 + {$random(seed)} % 512) : 2 + {$random(seed)} % 4;
      chain[9*i +: 9] = div_d[i][8:0];
    end
    for (int k = 0; k < NUM_POST; k++)
      chain[CHAIN_DELAY_BASE + 5*k +: 5] = 5'($random(seed));
  endtask : build
  task automatic frame(input logic [7:0] h);
    half <= h;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    wait_for(2, 64'(chain[CHAIN_DELAY_BASE +: 50]), 3000);
  endtask : frame
  // vco ticks over one full period of output k
  task automatic measure(input int k, input int exp_div);
    int ticks, m, rises;
    logic prev;
    ticks = 0;
    m = 0;
    rises = 0;
    prev = 1'b1;
    while (rises < 2 && m < 2000)
    begin
      @(negedge clk_i);
      m++;
      if (rises == 1 && vco === 1'b1) ticks++;
      if (outs[k] === 1'b1 && prev === 1'b0) rises++;
      prev = outs[k];
    end
    @(posedge clk_i);
    check(64'(ticks), 64'(exp_div));
  endtask : measure
  initial
  begin
    seed = 65805;
    {rst_i, scan_clear, en0} = 3'b111;
    {cyc, stb, we, ext_req, go} = '0;
    {adr, wdat, half, chain} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    scan_clear <= 1'b0;
    @(posedge clk_i);
    wb(0, CTRL_OFFSET, 0);
    check(64'(rdat), 64'(CTRL_RESET));
    wb(0, DIVNM_OFFSET, 0);
    check(64'(rdat), 64'h0001_0001);
    wb(0, 8'h10, 0);
    check(64'(rdat), 64'h0);
    wb(1, CTRL_OFFSET, 32'h47);
    build(0);
    frame(4);
    check(64'(n < 2500), 64'h1);
    wb(0, DIVNM_OFFSET, 0);
    check(64'(rdat), 64'({7'h0, chain[17:9], 7'h0, chain[8:0]}));
    wb(0, STATUS_OFFSET, 0);
    check(64'(rdat[STAT_RECONFIG_DONE_BIT]), 64'h1);
    for (int k = 0; k < NUM_POST; k++)
      measure(k, div_d[POST_REGIONAL_BASE + k]);
    wb(1, CTRL_OFFSET, 32'h57);
    @(negedge clk_i);
    check(64'(eb ^ ea), 64'h0F);
    @(posedge clk_i);
    build(1);
    frame(8);
    wb(0, DIVNM_OFFSET, 0);
    check(64'(rdat), 64'h0);
    old_dly = dly;
    build(0);
    fork
      begin
        half <= 8'h04;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (1400) @(posedge clk_i); // cut frame: the leftover bits must never load
      end
      begin
        repeat (400) @(posedge clk_i);
        scan_clear <= 1'b1;
        @(posedge clk_i);
        scan_clear <= 1'b0;
      end
    join
    check(64'(dly), 64'(old_dly));
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    wait_for(1, 1, 2000);
    en0 <= 1'b0;
    wait_for(0, 1, 200);
    wait_for(1, 1, 400);
    wb(0, STATUS_OFFSET, 0);
    check(64'(rdat[STAT_SWITCH_EVENT_BIT]), 64'h1);
    en0 <= 1'b1;
    ext_req <= 1'b1;
    wait_for(0, 0, 200);
    ext_req <= 1'b0;
    wb(1, CTRL_OFFSET, 32'h27);
    wait_for(0, 1, 200);
    summarize();
  end
  initial
  begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule : pll_counter_switchover_reconfig_bench

// ==== verif/pll_counter_switchover_reconfig_properties.sv ====
`timescale 1ns/10ps
module pll_ctrl_properties
  import pll_ctrl_pkg::*;
#(
  parameter int INSTANCE_ID = 5,
  parameter int RELOCK_LIMIT = RELOCK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scan_clk_i,
  input wire logic vco_tick_o,
  input wire logic active_ref_o,
  input wire logic locked_o,
  input wire logic [1:0] regional_clk_o,
  input wire logic [3:0] global_clk_o,
  input wire logic [3:0] ext_out_a_o,
  input wire logic [3:0] ext_out_b_o,
  input wire logic single_ext_out_o,
  input wire logic [NUM_POST*DELAY_W-1:0] delay_step_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic scan_prev_q;
  logic [7:0] scan_idle_q;
  // cycles since the shift clock pin last moved, saturating
  always_ff @(posedge clk_i)
  begin
    scan_prev_q <= scan_clk_i;
    if (rst_i)
      scan_idle_q <= 8'hFF;
    else if (scan_clk_i != scan_prev_q)
      scan_idle_q <= 8'h00;
    else if (scan_idle_q != 8'hFF)
      scan_idle_q <= scan_idle_q + 8'h01;
  end
  AST_ACK_ANSWER: assert property ((ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property ((ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  AST_UNMAPPED_READ: assert property ((ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h10)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  AST_RESET_STATE: assert property (disable iff (1'b0) (rst_i && ce_i) |=> (!wb_ack_o && !active_ref_o
    && !locked_o && delay_step_o == '0 && global_clk_o == 4'h0 && regional_clk_o == 2'h0))
    else $error("outputs not cleared by reset");
  AST_SINGLE_SOURCE: assert property (single_ext_out_o == ((INSTANCE_ID == 11 || INSTANCE_ID == 12)
    ? global_clk_o[0] : 1'b0)) else $error("single output source wrong");
  AST_PAIR_PHASE: assert property ((ext_out_b_o == ext_out_a_o) || (ext_out_b_o == ~ext_out_a_o))
    else $error("pair outputs neither in phase nor inverted");
  AST_SWITCH_DROPS_LOCK: assert property ($changed(active_ref_o) |-> ##[0:1] !locked_o)
    else $error("lock kept across switchover");
  AST_VCO_RUNS: assert property ($changed(active_ref_o) |-> ##[1:300] vco_tick_o)
    else $error("vco stopped during switchover");
  AST_LOAD_AFTER_SHIFT: assert property (($changed(delay_step_o) && !$past(rst_i))
    |-> scan_idle_q < 8'h28) else $error("delay codes changed without shifting");
  COV_SWITCH: cover property ($changed(active_ref_o));
  COV_LOAD: cover property ($changed(delay_step_o));
  COV_LOCK: cover property ($rose(locked_o));
endmodule : pll_ctrl_properties

bind pll_counter_switchover_reconfig pll_ctrl_properties #(.INSTANCE_ID(INSTANCE_ID), .RELOCK_LIMIT(RELOCK_LIMIT))
  pll_ctrl_properties_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_clk_i(scan_clk_i),
  .vco_tick_o(vco_tick_o), .active_ref_o(active_ref_o), .locked_o(locked_o), .regional_clk_o(regional_clk_o),
  .global_clk_o(global_clk_o), .ext_out_a_o(ext_out_a_o), .ext_out_b_o(ext_out_b_o),
  .single_ext_out_o(single_ext_out_o), .delay_step_o(delay_step_o));

// ==== verif/scan_feeder.sv ====
`timescale 1ns/10ps
module scan_feeder
  import pll_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] half_i,
  input wire logic [CHAIN_LEN-1:0] bits_i,
  output logic scan_clk_o,
  output logic scan_data_o
);
  // shift clock rests low between frames; data line toggles so no stale bit lingers
  initial
  begin
    scan_clk_o = 1'b0;
    scan_data_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        // whole chain every frame, top bit first
        for (int i = CHAIN_LEN - 1; i >= 0; i--)
        begin
          scan_data_o <= bits_i[i];
          repeat (half_i) @(posedge clk_i);
          scan_clk_o <= 1'b1;
          repeat (half_i) @(posedge clk_i);
          scan_clk_o <= 1'b0;
        end
      end
      else
        scan_data_o <= ~scan_data_o;
    end
  end
endmodule : scan_feeder
